// [design/pci_qsplit_pkg.sv]
/*
 Shared constants and state types for the 32-bit PCI target read path with a
 64-bit local word. Assumes both ends run on the one PCI clock.
*/
package pci_qsplit_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int AD_W = 32;
   localparam int QW_W = 64;
   localparam int CBE_W = 4;
   localparam int QW_SHIFT = 3;
   localparam int QADDR_W = AD_W - QW_SHIFT;
   localparam int QWORD_SEL_BIT = 2;

   // ----------------------------------------
   // Bus commands answered by the read path
   // ----------------------------------------
   localparam logic [CBE_W-1:0] CMD_MEM_READ = 4'h6;
   localparam logic [CBE_W-1:0] CMD_MEM_READ_MULT = 4'hC;
   localparam logic [CBE_W-1:0] CMD_MEM_READ_LINE = 4'hE;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic PIN_IDLE_N = 1'b1;
   localparam logic [1:0] HELD_RST = 2'h0;
   localparam logic [AD_W-1:0] AD_RST = 32'h0000_0000;
   localparam logic [QW_W-1:0] QW_RST = 64'h0000_0000_0000_0000;

   typedef enum logic [2:0] {T_IDLE, T_DECODE, T_HIT, T_ACTIVE, T_TURN, T_MISS} tgt_state_t;
   typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA, M_TURN} mst_state_t;
endpackage

// [design/pci_qword_if.sv]
/*
 Carrier joining the PCI target end and the master/back-end end.
 Assumes each driver gives its value and an active-low enable; pull-ups are
 modelled by resolving an undriven line to all ones.
*/
`timescale 1ns/1ps
interface pci_qword_if;
   import pci_qsplit_pkg::*;
   // Pins driven by the master
   logic frame_n_o;
   logic frame_oe_n;
   logic irdy_n_o;
   logic irdy_oe_n;
   logic [CBE_W-1:0] cbe_n_o;
   logic cbe_oe_n;
   logic [AD_W-1:0] ad_m_o;
   logic ad_m_oe_n;
   // Pins driven by the target
   logic [AD_W-1:0] ad_t_o;
   logic ad_t_oe_n;
   logic trdy_n_o;
   logic trdy_oe_n;
   logic devsel_n_o;
   logic devsel_oe_n;
   // Resolved bus lines
   logic frame_n;
   logic irdy_n;
   logic trdy_n;
   logic devsel_n;
   logic [CBE_W-1:0] cbe_n;
   logic [AD_W-1:0] ad;
   // Local back-end side
   logic [AD_W-1:0] local_addr;
   logic bar_hit;
   logic backend_ready_n;
   logic low_half_xfer_strobe_n;
   logic high_half_xfer_strobe_n;
   logic [QW_W-1:0] local_rdata;

   assign frame_n = frame_oe_n ? 1'b1 : frame_n_o;
   assign irdy_n = irdy_oe_n ? 1'b1 : irdy_n_o;
   assign trdy_n = trdy_oe_n ? 1'b1 : trdy_n_o;
   assign devsel_n = devsel_oe_n ? 1'b1 : devsel_n_o;
   assign cbe_n = cbe_oe_n ? {CBE_W{1'b1}} : cbe_n_o;
   assign ad = !ad_t_oe_n ? ad_t_o : (!ad_m_oe_n ? ad_m_o : {AD_W{1'b1}});

   modport target(
      input frame_n, irdy_n, cbe_n, ad, backend_ready_n, local_rdata,
      output ad_t_o, ad_t_oe_n, trdy_n_o, trdy_oe_n, devsel_n_o, devsel_oe_n,
      output local_addr, bar_hit, low_half_xfer_strobe_n, high_half_xfer_strobe_n
   );
   modport initiator(
      input trdy_n, devsel_n, ad, local_addr, bar_hit,
      input low_half_xfer_strobe_n, high_half_xfer_strobe_n,
      output frame_n_o, frame_oe_n, irdy_n_o, irdy_oe_n, cbe_n_o, cbe_oe_n,
      output ad_m_o, ad_m_oe_n, backend_ready_n, local_rdata
   );
endinterface

// [design/pci_target_qword_read.sv]
/*
 PCI target burst read path: 32-bit PCI data phases fed from 64-bit local
 words, half by half, under two alternating transfer strobes.
 Assumes the master and back-end share the PCI clock and keep their side.
*/
`timescale 1ns/1ps
module pci_target_qword_read #(
   parameter logic [31:0] BAR_BASE = 32'h1000_0000,
   parameter logic [31:0] BAR_MASK = 32'hFFFF_0000
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // PCI pins and local back-end
   pci_qword_if.target bus,
   // Status
   output logic busy
);
   import pci_qsplit_pkg::*;

   tgt_state_t state_r;
   logic frame_prev_r;
   logic rdy_prev_r;
   logic started_r;
   logic next_high_r;
   logic low_stb_r;
   logic high_stb_r;
   logic trdy_r;
   logic devsel_r;
   logic ctl_oe_r;
   logic ad_drive_r;
   logic bar_hit_r;
   logic [AD_W-1:0] addr_r;
   logic [CBE_W-1:0] cmd_r;
   logic [1:0] held_r;
   logic [AD_W-1:0] slot0_r;
   logic [AD_W-1:0] slot1_r;

   logic rdy_now;
   logic irdy_now;
   logic consume;
   logic last_phase;
   logic load;
   logic [AD_W-1:0] load_data;
   logic [1:0] held_nxt;
   logic [AD_W-1:0] slot0_nxt;
   logic [AD_W-1:0] slot1_nxt;
   logic gate;
   logic fetch_ok;
   logic low_stb_nxt;
   logic high_stb_nxt;
   logic trdy_nxt;
   logic read_cmd;
   logic addr_hit;

   // ----------------------------------------
   // Handshake terms
   // ----------------------------------------
   assign rdy_now = !bus.backend_ready_n;
   assign irdy_now = !bus.irdy_n;
   assign consume = trdy_r & irdy_now;
   assign last_phase = consume & bus.frame_n;
   assign load = low_stb_r | high_stb_r;
   // Half selection: the strobe on the pins this cycle picks the half of the word
   // the back-end holds now
   assign load_data = low_stb_r ? bus.local_rdata[AD_W-1:0] : bus.local_rdata[QW_W-1:AD_W];
   assign read_cmd = (cmd_r == CMD_MEM_READ) | (cmd_r == CMD_MEM_READ_MULT) | (cmd_r == CMD_MEM_READ_LINE);
   assign addr_hit = ((addr_r & BAR_MASK) == BAR_BASE) & (addr_r[1:0] == 2'h0);

   // ----------------------------------------
   // Two-entry output hold
   // ----------------------------------------
   // A strobe promises the back-end a half has gone; the second entry keeps
   // that half if the master pauses irdy in the same cycle.
   always_comb begin
      slot0_nxt = consume ? slot1_r : slot0_r;
      slot1_nxt = slot1_r;
      held_nxt = held_r - {1'b0, consume};
      if (load) begin
         if (held_nxt == 2'h0) begin
            slot0_nxt = load_data;
         end else begin
            slot1_nxt = load_data;
         end
         held_nxt = held_nxt + 2'h1;
      end
   end

   // ----------------------------------------
   // Strobe and trdy decisions
   // ----------------------------------------
   always_comb begin
      // Before the first data phase only the low strobe's own ready term applies
      gate = started_r ? (rdy_now & rdy_prev_r) : 1'b1;
      fetch_ok = (state_r == T_ACTIVE) & !last_phase & irdy_now & (held_nxt <= 2'h1) & gate;
      low_stb_nxt = fetch_ok & !next_high_r & rdy_now;
      high_stb_nxt = fetch_ok & next_high_r;
      trdy_nxt = (state_r == T_ACTIVE) & !last_phase & (held_nxt != 2'h0) & rdy_now & rdy_prev_r;
   end

   // ----------------------------------------
   // Transaction state
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= T_IDLE;
      end else begin
         unique case (state_r)
            T_IDLE: begin
               if (!bus.frame_n && frame_prev_r) begin
                  state_r <= T_DECODE;
               end
            end
            T_DECODE: begin
               state_r <= (read_cmd && addr_hit) ? T_HIT : T_MISS;
            end
            T_HIT: begin
               state_r <= T_ACTIVE;
            end
            T_ACTIVE: begin
               if (last_phase) begin
                  state_r <= T_TURN;
               end
            end
            T_TURN: begin
               state_r <= T_IDLE;
            end
            T_MISS: begin
               if (bus.frame_n && bus.irdy_n) begin
                  state_r <= T_IDLE;
               end
            end
         endcase
      end
   end

   // Address phase capture
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         frame_prev_r <= PIN_IDLE_N;
         addr_r <= AD_RST;
         cmd_r <= {CBE_W{PIN_IDLE_N}};
      end else begin
         frame_prev_r <= bus.frame_n;
         if (state_r == T_IDLE && !bus.frame_n && frame_prev_r) begin
            addr_r <= bus.ad;
            cmd_r <= bus.cbe_n;
         end
      end
   end

   // Ready history and half sequencing
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdy_prev_r <= 1'b0;
         started_r <= 1'b0;
         next_high_r <= 1'b0;
         low_stb_r <= 1'b0;
         high_stb_r <= 1'b0;
      end else begin
         rdy_prev_r <= rdy_now;
         low_stb_r <= low_stb_nxt;
         high_stb_r <= high_stb_nxt;
         if (state_r == T_DECODE) begin
            next_high_r <= addr_r[QWORD_SEL_BIT];
            started_r <= 1'b0;
         end else begin
            if (low_stb_nxt || high_stb_nxt) begin
               next_high_r <= !next_high_r;
            end
            if (trdy_r) begin
               started_r <= 1'b1;
            end
         end
      end
   end

   // Data hold; prefetched halves are dropped at the end of the burst
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         held_r <= HELD_RST;
         slot0_r <= AD_RST;
         slot1_r <= AD_RST;
      end else if (state_r == T_ACTIVE) begin
         held_r <= last_phase ? HELD_RST : held_nxt;
         slot0_r <= slot0_nxt;
         slot1_r <= slot1_nxt;
      end else begin
         held_r <= HELD_RST;
      end
   end

   // ----------------------------------------
   // Pin control
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         trdy_r <= 1'b0;
         devsel_r <= 1'b0;
         ctl_oe_r <= 1'b0;
         ad_drive_r <= 1'b0;
         bar_hit_r <= 1'b0;
      end else begin
         trdy_r <= trdy_nxt;
         unique case (state_r)
            T_DECODE: begin
               bar_hit_r <= read_cmd & addr_hit;
            end
            T_HIT: begin
               devsel_r <= 1'b1;
               ctl_oe_r <= 1'b1;
               ad_drive_r <= 1'b1;
            end
            T_ACTIVE: begin
               if (last_phase) begin
                  devsel_r <= 1'b0;
                  ad_drive_r <= 1'b0;
                  bar_hit_r <= 1'b0;
               end
            end
            T_TURN: begin
               ctl_oe_r <= 1'b0;
            end
            default: begin
               devsel_r <= 1'b0;
               ctl_oe_r <= 1'b0;
               ad_drive_r <= 1'b0;
               bar_hit_r <= 1'b0;
            end
         endcase
      end
   end

   assign bus.ad_t_o = slot0_r;
   assign bus.ad_t_oe_n = !ad_drive_r;
   assign bus.trdy_n_o = !trdy_r;
   assign bus.trdy_oe_n = !ctl_oe_r;
   assign bus.devsel_n_o = !devsel_r;
   assign bus.devsel_oe_n = !ctl_oe_r;
   assign bus.local_addr = addr_r;
   assign bus.bar_hit = bar_hit_r;
   assign bus.low_half_xfer_strobe_n = !low_stb_r;
   assign bus.high_half_xfer_strobe_n = !high_stb_r;
   assign busy = (state_r != T_IDLE);
endmodule

// [design/pci_master_backend.sv]
/*
 The far end of the read path: a simple PCI burst-read master together with
 the local back-end that supplies 64-bit words from a user-side store.
 Assumes the store answers be_rd_addr combinationally on be_rd_data.
*/
`timescale 1ns/1ps
module pci_master_backend #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // PCI pins and back-end wires
   pci_qword_if.initiator bus,
   // Burst request
   input wire logic start,
   input wire logic [pci_qsplit_pkg::AD_W-1:0] start_addr,
   input wire logic [CNT_W-1:0] burst_len,
   input wire logic [pci_qsplit_pkg::CBE_W-1:0] byte_en_n,
   input wire logic stall,
   // Read results
   output logic [pci_qsplit_pkg::AD_W-1:0] rd_data,
   output logic rd_valid,
   output logic done,
   output logic busy,
   // Back-end store
   input wire logic be_ready,
   output logic [pci_qsplit_pkg::QADDR_W-1:0] be_rd_addr,
   input wire logic [pci_qsplit_pkg::QW_W-1:0] be_rd_data
);
   import pci_qsplit_pkg::*;

   mst_state_t state_r;
   logic frame_r;
   logic frame_oe_r;
   logic irdy_r;
   logic irdy_oe_r;
   logic [CBE_W-1:0] cbe_r;
   logic cbe_oe_r;
   logic [AD_W-1:0] ad_r;
   logic ad_oe_r;
   logic [CNT_W-1:0] rem_r;
   logic hit_prev_r;
   logic [QADDR_W-1:0] qaddr_r;
   logic [QADDR_W-1:0] qaddr_nxt;
   logic [QW_W-1:0] rdata_r;
   logic ready_n_r;
   logic xfer;
   logic [CNT_W-1:0] rem_nxt;

   assign xfer = (state_r == M_DATA) & irdy_r & !bus.trdy_n;
   assign rem_nxt = rem_r - {{(CNT_W-1){1'b0}}, xfer};

   // ----------------------------------------
   // Master sequencing
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= M_IDLE;
         frame_r <= 1'b0;
         frame_oe_r <= 1'b0;
         irdy_r <= 1'b0;
         irdy_oe_r <= 1'b0;
         cbe_r <= {CBE_W{PIN_IDLE_N}};
         cbe_oe_r <= 1'b0;
         ad_r <= AD_RST;
         ad_oe_r <= 1'b0;
         rem_r <= '0;
         rd_data <= AD_RST;
         rd_valid <= 1'b0;
         done <= 1'b0;
      end else begin
         rd_valid <= xfer;
         done <= xfer & (rem_r == 1);
         if (xfer) begin
            rd_data <= bus.ad;
         end
         unique case (state_r)
            M_IDLE: begin
               irdy_oe_r <= 1'b0;
               if (start && burst_len != '0) begin
                  state_r <= M_ADDR;
                  frame_r <= 1'b1;
                  frame_oe_r <= 1'b1;
                  irdy_oe_r <= 1'b1;
                  ad_r <= start_addr;
                  ad_oe_r <= 1'b1;
                  cbe_r <= CMD_MEM_READ_MULT;
                  cbe_oe_r <= 1'b1;
                  rem_r <= burst_len;
               end
            end
            M_ADDR: begin
               state_r <= M_DATA;
               ad_oe_r <= 1'b0;
               cbe_r <= byte_en_n;
               irdy_r <= (rem_r == 1) | !stall;
               frame_r <= (rem_r != 1);
            end
            M_DATA: begin
               rem_r <= rem_nxt;
               cbe_r <= byte_en_n;
               if (xfer && rem_r == 1) begin
                  state_r <= M_TURN;
                  frame_oe_r <= 1'b0;
                  cbe_oe_r <= 1'b0;
                  irdy_r <= 1'b0;
               end else begin
                  // An offered irdy stays until the phase completes
                  irdy_r <= (irdy_r & !xfer) | (rem_nxt == 1) | !stall;
                  frame_r <= (rem_nxt != 1);
               end
            end
            M_TURN: begin
               state_r <= M_IDLE;
               irdy_oe_r <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Back-end word counter
   // ----------------------------------------
   always_comb begin
      qaddr_nxt = qaddr_r;
      if (bus.bar_hit && !hit_prev_r) begin
         qaddr_nxt = bus.local_addr[AD_W-1:QW_SHIFT];
      end else if (!bus.high_half_xfer_strobe_n) begin
         qaddr_nxt = qaddr_r + {{(QADDR_W-1){1'b0}}, 1'b1};
      end
   end

   // Word stays put unless the counter moves, so the target sees it stable
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hit_prev_r <= 1'b0;
         qaddr_r <= '0;
         rdata_r <= QW_RST;
         ready_n_r <= PIN_IDLE_N;
      end else begin
         hit_prev_r <= bus.bar_hit;
         qaddr_r <= qaddr_nxt;
         rdata_r <= be_rd_data;
         ready_n_r <= !(be_ready && bus.bar_hit);
      end
   end

   assign be_rd_addr = qaddr_nxt;
   assign bus.local_rdata = rdata_r;
   assign bus.backend_ready_n = ready_n_r;
   assign bus.frame_n_o = !frame_r;
   assign bus.frame_oe_n = !frame_oe_r;
   assign bus.irdy_n_o = !irdy_r;
   assign bus.irdy_oe_n = !irdy_oe_r;
   assign bus.cbe_n_o = cbe_r;
   assign bus.cbe_oe_n = !cbe_oe_r;
   assign bus.ad_m_o = ad_r;
   assign bus.ad_m_oe_n = !ad_oe_r;
   assign busy = (state_r != M_IDLE);
endmodule

// [bench/pci_qsplit_sva.sv]
/*
 Concurrent checks on the PCI read path carrier, both ends being design code.
 Assumes the testbench feeds the resolved lines and enables of one carrier.
*/
`timescale 1ns/1ps
module pci_qsplit_sva (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Bus lines and enables
   input wire logic frame_n,
   input wire logic irdy_n,
   input wire logic trdy_n,
   input wire logic devsel_n,
   input wire logic ad_t_oe_n,
   input wire logic trdy_oe_n,
   input wire logic devsel_oe_n,
   // Back-end side
   input wire logic bar_hit,
   input wire logic backend_ready_n,
   input wire logic low_half_xfer_strobe_n,
   input wire logic high_half_xfer_strobe_n
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // ----------------------------------------
   // Strobes
   // ----------------------------------------
   strobe_one_half_a: assert property (low_half_xfer_strobe_n || high_half_xfer_strobe_n)
      else $error("both half strobes low");
   high_after_irdy_a: assert property (!high_half_xfer_strobe_n |-> $past(!irdy_n))
      else $error("high strobe without irdy before");
   low_after_ready_a: assert property (!low_half_xfer_strobe_n |-> $past(!irdy_n) && $past(!backend_ready_n))
      else $error("low strobe without irdy and ready before");
   high_one_cycle_a: assert property (!high_half_xfer_strobe_n |=> high_half_xfer_strobe_n)
      else $error("high strobe held two cycles");

   // ----------------------------------------
   // Data phases and turnaround
   // ----------------------------------------
   trdy_ready_hist_a: assert property (!trdy_n |-> $past(!backend_ready_n, 1) && $past(!backend_ready_n, 2))
      else $error("trdy without two ready cycles");
   trdy_drives_ad_a: assert property (!trdy_n |-> !ad_t_oe_n)
      else $error("trdy low while ad undriven");
   turn_release_a: assert property (frame_n && !trdy_n && !irdy_n
      |=> trdy_n && devsel_n && ad_t_oe_n && !bar_hit && high_half_xfer_strobe_n)
      else $error("turnaround not honoured");
   idle_release_a: assert property (frame_n && !trdy_n && !irdy_n |-> ##2 trdy_oe_n && devsel_oe_n)
      else $error("devsel or trdy still driven in idle");
   hit_clear_a: assert property ($fell(bar_hit) |-> $past(frame_n && !trdy_n && !irdy_n))
      else $error("bar hit cleared off the turnaround");
endmodule

// [bench/tb.sv]
/*
 Self-checking bench: target and master/back-end ends joined by the carrier.
 Assumes the store answers the back-end address combinationally.
*/
`timescale 1ns/1ps
module tb;
   import pci_qsplit_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic [AD_W-1:0] start_addr = 32'h0;
   logic [15:0] burst_len = 16'h0;
   logic [CBE_W-1:0] byte_en_n = 4'h0;
   logic stall = 1'b0;
   logic be_ready = 1'b1;
   logic [AD_W-1:0] rd_data;
   logic rd_valid;
   logic done;
   logic m_busy;
   logic t_busy;
   logic [QADDR_W-1:0] be_rd_addr;
   logic [QW_W-1:0] be_rd_data;
   int failures = 0;
   int n_compared = 0;

   pci_qword_if bus();
   pci_target_qword_read i_pci_target_qword_read (.ref_clk(ref_clk), .rst(rst), .bus(bus.target), .busy(t_busy));
   pci_master_backend i_pci_master_backend (.ref_clk(ref_clk), .rst(rst), .bus(bus.initiator), .start(start),
      .start_addr(start_addr), .burst_len(burst_len), .byte_en_n(byte_en_n), .stall(stall),
      .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .busy(m_busy), .be_ready(be_ready),
      .be_rd_addr(be_rd_addr), .be_rd_data(be_rd_data));
   pci_qsplit_sva i_pci_qsplit_sva (.ref_clk(ref_clk), .rst(rst), .frame_n(bus.frame_n), .irdy_n(bus.irdy_n),
      .trdy_n(bus.trdy_n), .devsel_n(bus.devsel_n), .ad_t_oe_n(bus.ad_t_oe_n), .trdy_oe_n(bus.trdy_oe_n),
      .devsel_oe_n(bus.devsel_oe_n), .bar_hit(bus.bar_hit), .backend_ready_n(bus.backend_ready_n),
      .low_half_xfer_strobe_n(bus.low_half_xfer_strobe_n), .high_half_xfer_strobe_n(bus.high_half_xfer_strobe_n));

   // Store: each half tags its qword index, so a wrong half or word shows at once
   assign be_rd_data = {3'h5, be_rd_addr, 3'h3, be_rd_addr};

   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end

   // ----------------------------------------
   // Checking helpers
   // ----------------------------------------
   function automatic logic [31:0] exp_dw(input logic [31:0] a);
      return {(a[2] ? 3'h5 : 3'h3), a[31:3]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Stall spans 3 cycles from st, ready drops for 6 cycles from rd (counted from start)
   task automatic burst(input string name, input logic [31:0] a, input int len, input logic [3:0] be,
         input int st, input int rd);
      int k;
      int nw;
      int nr;
      logic [31:0] wa;
      logic [31:0] ra;
      k = 0;
      nw = 0;
      nr = 0;
      wa = a;
      ra = a;
      @(posedge ref_clk);
      start <= 1'b1;
      start_addr <= a;
      burst_len <= len[15:0];
      byte_en_n <= be;
      @(posedge ref_clk);
      start <= 1'b0;
      repeat (400) begin
         @(posedge ref_clk);
         stall <= (k >= st && k < st + 3);
         be_ready <= !(k >= rd && k < rd + 6);
         @(negedge ref_clk);
         k++;
         if (bus.trdy_n === 1'b0 && bus.irdy_n === 1'b0) begin
            check(bus.ad, exp_dw(wa));
            check({28'h0, bus.cbe_n}, {28'h0, be});
            wa = wa + 32'h4;
            nw++;
         end
         if (rd_valid === 1'b1) begin
            check(rd_data, exp_dw(ra));
            ra = ra + 32'h4;
            nr++;
         end
         if (done === 1'b1)
            break;
      end
      check(32'(nw), 32'(len));
      check(32'(nr), 32'(len));
      // Inputs only move on the rising edge, never on the sampling edge
      @(posedge ref_clk);
      stall <= 1'b0;
      be_ready <= 1'b1;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      check({31'h0, bus.bar_hit}, 32'h0);
      check({30'h0, bus.trdy_oe_n, bus.devsel_oe_n}, 32'h3);
      check({30'h0, t_busy, m_busy}, 32'h0);
      $display("test %s done", name);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_aligned;
      burst("aligned", 32'h1000_0100, 3, 4'h0, 1000, 1000);
   endtask
   task automatic t_unaligned;
      burst("unaligned", 32'h1000_0204, 3, 4'h3, 1000, 1000);
   endtask
   task automatic t_single_upper;
      burst("single_upper", 32'h1000_0FFC, 1, 4'hC, 1000, 1000);
   endtask
   task automatic t_ready_late;
      burst("ready_late", 32'h1000_0300, 8, 4'hA, 1000, 0);
   endtask
   task automatic t_ready_gap;
      burst("ready_gap", 32'h1000_0404, 9, 4'h5, 1000, 8);
   endtask
   task automatic t_master_stall;
      burst("master_stall", 32'h1000_0500, 10, 4'hF, 6, 1000);
   endtask

   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      t_aligned();
      t_unaligned();
      t_single_upper();
      t_ready_late();
      t_ready_gap();
      t_master_stall();
      results();
   end

   // Six bursts take well under two hundred cycles; this leaves wide margin
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      results();
   end
endmodule
